// file: shared/sos_regs.vh
// Constants of the status output selector
`ifndef SOS_REGS_VH
`define SOS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SOS_ADDR_FUNC_SEL    4'h0
`define SOS_ADDR_UPPER       4'h1
`define SOS_ADDR_LOWER       4'h2
`define SOS_ADDR_STATUS      4'h3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define SOS_FUNC_SEL_RESET   4'h9
`define SOS_FUNC_SEL_MAX     4'hC
`define SOS_UPPER_RESET      16'h0000
`define SOS_LOWER_RESET      16'h0000

// ----------------------------------------
// Function select codes
// ----------------------------------------
`define SOS_CODE_RUNNING     4'h0
`define SOS_CODE_HEALTHY     4'h1
`define SOS_CODE_AT_SPEED    4'h2
`define SOS_CODE_SPEED_NZ    4'h3
`define SOS_CODE_SPEED_LIM   4'h4
`define SOS_CODE_CURR_LIM    4'h5
`define SOS_CODE_TORQ_LIM    4'h6
`define SOS_CODE_AIN2_LIM    4'h7
`define SOS_CODE_A_SPEED     4'h8
`define SOS_CODE_A_CURR      4'h9
`define SOS_CODE_A_TORQ      4'hA
`define SOS_CODE_A_POWER     4'hB
`define SOS_CODE_A_PID       4'hC

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SOS_ST_DIGITAL_BIT   0
`define SOS_ST_ANALOG_BIT    1
`define SOS_ST_HYST_LSB      2

`endif

// file: design/sos_sync.v
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps

module sos_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             reset_i,
  // Levels
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule // sos_sync

// file: design/sos_hyst.v
// Hysteresis comparators, one per limit quantity
`timescale 1ns/1ps
`include "sos_regs.vh"

module sos_hyst #(
  parameter WIDTH = 16,
  parameter NUM   = 4
) (
  // Clock and reset
  input  wire                 sys_clk_i,
  input  wire                 reset_i,
  // Quantities and thresholds
  input  wire [NUM*WIDTH-1:0] value_i,
  input  wire [WIDTH-1:0]     upper_i,
  input  wire [WIDTH-1:0]     lower_i,
  // Held states
  output wire [NUM-1:0]       state_o
);

  genvar g;
  generate
    for (g = 0; g < NUM; g = g + 1) begin : g_cmp
      wire [WIDTH-1:0] val = value_i[g*WIDTH +: WIDTH];
      reg              held;
      always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          held <= 1'b0;
        end else if (val > upper_i) begin
          held <= 1'b1;
        end else if (val < lower_i) begin
          held <= 1'b0;
        end
      end
      assign state_o[g] = held;
    end
  endgenerate

endmodule // sos_hyst

// file: design/sos_top.v
// Status output selector for the second configurable output terminal
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "sos_regs.vh"

module sos_top #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             reset_i,
  // Register port
  input  wire [3:0]       reg_addr_i,
  input  wire [15:0]      reg_wdata_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  output reg  [15:0]      reg_rdata_o,
  // Drive conditions, from pins of the drive controller
  input  wire             drive_running_i,
  input  wire             fault_active_i,
  // Drive quantities, same clock domain
  input  wire [WIDTH-1:0] output_freq_i,
  input  wire [WIDTH-1:0] setpoint_freq_i,
  input  wire [WIDTH-1:0] motor_speed_i,
  input  wire [WIDTH-1:0] motor_current_i,
  input  wire [WIDTH-1:0] motor_torque_i,
  input  wire [WIDTH-1:0] analog_in2_i,
  input  wire [WIDTH-1:0] motor_power_i,
  input  wire [WIDTH-1:0] pid_output_i,
  // Terminal outputs
  output reg              digital_out_o,
  output reg              analog_mode_o,
  output reg  [WIDTH-1:0] analog_value_o
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg  [3:0]       output2_function_select;
  reg  [WIDTH-1:0] limit_upper_threshold;
  reg  [WIDTH-1:0] limit_lower_threshold;

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      output2_function_select <= `SOS_FUNC_SEL_RESET;
      limit_upper_threshold   <= `SOS_UPPER_RESET;
      limit_lower_threshold   <= `SOS_LOWER_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SOS_ADDR_FUNC_SEL: begin
          // Out-of-range codes are ignored
          if (reg_wdata_i[3:0] <= `SOS_FUNC_SEL_MAX && reg_wdata_i[15:4] == 12'h000) begin
            output2_function_select <= reg_wdata_i[3:0];
          end
        end
        `SOS_ADDR_UPPER: begin
          limit_upper_threshold <= reg_wdata_i[WIDTH-1:0];
        end
        `SOS_ADDR_LOWER: begin
          limit_lower_threshold <= reg_wdata_i[WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin conditions
  // ----------------------------------------
  wire [1:0] pins_sync;

  sos_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   ({fault_active_i, drive_running_i}),
    .sync_o    (pins_sync)
  );

  wire running = pins_sync[0];
  wire healthy = ~pins_sync[1];

  // ----------------------------------------
  // Limit comparators
  // ----------------------------------------
  wire [3:0] limit_state;

  sos_hyst #(
    .WIDTH (WIDTH),
    .NUM   (4)
  ) u_hyst (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .value_i   ({analog_in2_i, motor_torque_i, motor_current_i, motor_speed_i}),
    .upper_i   (limit_upper_threshold),
    .lower_i   (limit_lower_threshold),
    .state_o   (limit_state)
  );

  // ----------------------------------------
  // Output selection
  // ----------------------------------------
  reg             next_digital;
  reg             next_analog_mode;
  reg [WIDTH-1:0] next_analog_value;

  always @* begin
    next_digital      = 1'b0;
    next_analog_mode  = 1'b0;
    next_analog_value = {WIDTH{1'b0}};
    case (output2_function_select)
      `SOS_CODE_RUNNING:   next_digital = running;
      `SOS_CODE_HEALTHY:   next_digital = healthy;
      `SOS_CODE_AT_SPEED:  next_digital = (output_freq_i == setpoint_freq_i);
      `SOS_CODE_SPEED_NZ:  next_digital = (motor_speed_i != {WIDTH{1'b0}});
      `SOS_CODE_SPEED_LIM: next_digital = limit_state[0];
      `SOS_CODE_CURR_LIM:  next_digital = limit_state[1];
      `SOS_CODE_TORQ_LIM:  next_digital = limit_state[2];
      `SOS_CODE_AIN2_LIM:  next_digital = limit_state[3];
      `SOS_CODE_A_SPEED: begin
        next_analog_mode  = 1'b1;
        next_analog_value = motor_speed_i;
      end
      `SOS_CODE_A_CURR: begin
        next_analog_mode  = 1'b1;
        next_analog_value = motor_current_i;
      end
      `SOS_CODE_A_TORQ: begin
        next_analog_mode  = 1'b1;
        next_analog_value = motor_torque_i;
      end
      `SOS_CODE_A_POWER: begin
        next_analog_mode  = 1'b1;
        next_analog_value = motor_power_i;
      end
      `SOS_CODE_A_PID: begin
        next_analog_mode  = 1'b1;
        next_analog_value = pid_output_i;
      end
      default: begin
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      digital_out_o  <= 1'b0;
      analog_mode_o  <= 1'b0;
      analog_value_o <= {WIDTH{1'b0}};
    end else begin
      digital_out_o  <= next_digital;
      analog_mode_o  <= next_analog_mode;
      analog_value_o <= next_analog_value;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SOS_ADDR_FUNC_SEL: reg_rdata_o <= {12'h000, output2_function_select};
        `SOS_ADDR_UPPER:    reg_rdata_o <= limit_upper_threshold;
        `SOS_ADDR_LOWER:    reg_rdata_o <= limit_lower_threshold;
        `SOS_ADDR_STATUS:   reg_rdata_o <= {10'h000, limit_state, analog_mode_o, digital_out_o};
        default:            reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule // sos_top

// file: tb/sos_chk_assertions.sv
// Port checker of the status output selector
`timescale 1ns/1ps
`include "sos_regs.vh"
module sos_chk #(parameter WIDTH = 16) (
  input wire             sys_clk_i, reset_i, reg_wr_i, reg_rd_i,
  input wire             drive_running_i, fault_active_i, digital_out_o, analog_mode_o,
  input wire [3:0]       reg_addr_i,
  input wire [15:0]      reg_wdata_i, reg_rdata_o,
  input wire [WIDTH-1:0] output_freq_i, setpoint_freq_i, motor_speed_i, motor_current_i,
  input wire [WIDTH-1:0] motor_torque_i, analog_in2_i, motor_power_i, pid_output_i,
  input wire [WIDTH-1:0] analog_value_o
);
  reg [3:0]         sel, hs;
  reg [WIDTH-1:0]   up, lo, ana;
  reg               live;
  wire              hsel = hs[sel[1:0]];
  wire [4*WIDTH-1:0] q = {analog_in2_i, motor_torque_i, motor_current_i, motor_speed_i};
  integer           i;
  always @* begin
    case (sel)
      4'h8: ana = motor_speed_i;
      4'h9: ana = motor_current_i;
      4'hA: ana = motor_torque_i;
      4'hB: ana = motor_power_i;
      default: ana = pid_output_i;
    endcase
  end
  // Mirror of select, thresholds and held limit states
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel <= 4'h9;
      {up, lo, hs, live} <= 0;
    end else begin
      live <= 1'b1;
      if (reg_wr_i && reg_addr_i == `SOS_ADDR_FUNC_SEL && reg_wdata_i <= 16'h000C)
        sel <= reg_wdata_i[3:0];
      if (reg_wr_i && reg_addr_i == `SOS_ADDR_UPPER) up <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `SOS_ADDR_LOWER) lo <= reg_wdata_i;
      for (i = 0; i < 4; i = i + 1)
        hs[i] <= q[i*WIDTH+:WIDTH] > up ? 1'b1 : q[i*WIDTH+:WIDTH] < lo ? 1'b0 : hs[i];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_analog_mode: assert property (live |-> analog_mode_o == ($past(sel) > 4'h7))
    else $error("analog mode wrong");
  a_analog_value: assert property (live && $past(sel) > 4'h7 |->
    analog_value_o == $past(ana)) else $error("analog value wrong");
  a_digital_quiet: assert property (analog_mode_o |-> !digital_out_o)
    else $error("digital high in analog mode");
  a_drive_run: assert property (live && $past(sel) == 4'h0 |->
    digital_out_o == $past(drive_running_i, 3)) else $error("running bit wrong");
  a_drive_healthy: assert property (live && $past(sel) == 4'h1 |->
    digital_out_o == !$past(fault_active_i, 3)) else $error("healthy bit wrong");
  a_at_speed: assert property (live && $past(sel) == 4'h2 |->
    digital_out_o == ($past(output_freq_i) == $past(setpoint_freq_i)))
    else $error("at speed bit wrong");
  a_speed_nonzero: assert property (live && $past(sel) == 4'h3 |->
    digital_out_o == ($past(motor_speed_i) != 0)) else $error("speed bit wrong");
  a_limit_state: assert property (live && $past(sel[3:2]) == 2'b01 |->
    digital_out_o == $past(hsel)) else $error("limit bit wrong");
  a_read_select: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h0 |->
    reg_rdata_o == {12'h000, $past(sel)}) else $error("select readback wrong");
  c_limit: cover property (sel == 4'h4 && $rose(digital_out_o));
  c_pid: cover property (analog_mode_o && sel == 4'hC);
  c_read: cover property (reg_rd_i && reg_addr_i == 4'hF);
endmodule // sos_chk

bind sos_top sos_chk #(.WIDTH(WIDTH)) i_sos_chk (.*);

// file: tb/sos_relay.sv
// Relay model sensing the second output terminal
`timescale 1ns/1ps
module sos_relay (
  input  wire sys_clk_i,
  input  wire digital_out_o,
  input  wire analog_mode_o,
  output reg  relay_on_o
);
  // Coil pulls in only on a digital-mode high level
  always @(posedge sys_clk_i) begin
    relay_on_o <= digital_out_o & ~analog_mode_o;
  end
endmodule // sos_relay

// file: tb/tb.sv
// Testbench of the status output selector
`timescale 1ns/1ps
`include "sos_regs.vh"
module tb;
  reg         sys_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg         drive_running_i = 1'b0, fault_active_i = 1'b0;
  reg  [3:0]  reg_addr_i = 4'h0, c = 4'hC;
  reg  [15:0] reg_wdata_i = 0, output_freq_i = 0, setpoint_freq_i = 0, motor_speed_i = 0;
  reg  [15:0] motor_current_i = 0, motor_torque_i = 0, analog_in2_i = 0, motor_power_i = 0;
  reg  [15:0] pid_output_i = 0, r = 16'h004C;
  reg  [63:0] q;
  reg  [3:0]  hs = 4'h0;
  wire [15:0] reg_rdata_o, analog_value_o;
  wire        digital_out_o, analog_mode_o, relay_on_o;
  integer     errors = 0, n_compared = 0, k, j;
  sos_top i_sos_top (.*);
  sos_relay i_sos_relay (.*);
  always #2 sys_clk_i = ~sys_clk_i;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [18:0] ex(input [3:0] cd);
    reg b;
    begin
      case (cd)
        4'h0: b = drive_running_i;
        4'h1: b = ~fault_active_i;
        4'h2: b = output_freq_i == setpoint_freq_i;
        4'h3: b = motor_speed_i != 16'h0000;
        default: b = hs[cd[1:0]];
      endcase
      case (cd)
        4'h8: ex = {3'b100, motor_speed_i};
        4'h9: ex = {3'b100, motor_current_i};
        4'hA: ex = {3'b100, motor_torque_i};
        4'hB: ex = {3'b100, motor_power_i};
        4'hC: ex = {3'b100, pid_output_i};
        default: ex = {1'b0, b, b, 16'h0000};
      endcase
    end
  endfunction
  task chk(input string nm, input [18:0] e, input [18:0] s);
    begin
      n_compared = n_compared + 1;
      if (e !== s) begin
        errors = errors + 1;
        $display("FAIL %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", {3'b000, e}, {3'b000, reg_rdata_o});
    end
  endtask
  // New drive conditions, settle, then compare terminal and relay
  task look(input [3:0] cd, input [15:0] sp);
    begin
      @(posedge sys_clk_i);
      r = lfsr(r);
      drive_running_i <= r[0];
      fault_active_i <= r[1];
      output_freq_i <= r;
      setpoint_freq_i <= r[2] ? r : ~r;
      motor_speed_i <= sp;
      motor_current_i <= ~r;
      motor_torque_i <= {r[7:0], r[15:8]};
      analog_in2_i <= r ^ 16'h5A5A;
      motor_power_i <= r + 16'h0001;
      pid_output_i <= r - 16'h0003;
      repeat (4) @(posedge sys_clk_i);
      #1 q = {analog_in2_i, motor_torque_i, motor_current_i, motor_speed_i};
      for (k = 0; k < 4; k = k + 1)
        hs[k] = q[k*16+:16] > 16'h0064 ? 1'b1 : q[k*16+:16] < 16'h0032 ? 1'b0 : hs[k];
      chk("terminal", ex(cd), {analog_mode_o, digital_out_o, relay_on_o, analog_value_o});
    end
  endtask
  task test_done;
    begin
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(`SOS_ADDR_FUNC_SEL, 16'h0009);
    wr(`SOS_ADDR_FUNC_SEL, 16'h000D);
    rd(`SOS_ADDR_FUNC_SEL, 16'h0009);
    rd(4'hF, 16'h0000);
    wr(`SOS_ADDR_UPPER, 16'h0064);
    wr(`SOS_ADDR_LOWER, 16'h0032);
    for (j = 0; j < 26; j = j + 1) begin
      c = (c == 4'hC) ? 4'h0 : c + 4'h1;
      wr(`SOS_ADDR_FUNC_SEL, {12'h000, c});
      look(c, r[3] ? r : 16'h0000);
    end
    wr(`SOS_ADDR_FUNC_SEL, 16'h0004);
    look(4'h4, 16'h0065);
    look(4'h4, 16'h0064);
    look(4'h4, 16'h0032);
    look(4'h4, 16'h0031);
    look(4'h4, 16'h0064);
    rd(`SOS_ADDR_UPPER, 16'h0064);
    rd(`SOS_ADDR_LOWER, 16'h0032);
    rd(`SOS_ADDR_STATUS, {10'h000, hs, 1'b0, hs[0]});
    // Second reset in mid-run: select and thresholds return to defaults
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd(`SOS_ADDR_FUNC_SEL, 16'h0009);
    rd(`SOS_ADDR_UPPER, 16'h0000);
    test_done;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    errors = errors + 1;
    test_done;
  end
endmodule // tb
